// ### inc/flow_uart_params.svh
/*
  Offsets, field positions, reset values and counts of the flow-controlled UART channel.
  Assumes a 32-bit AHB-Lite slave whose registers each take one aligned word.
*/
// Contract
// - rx and tx FIFOs hold 64 characters; rx entries carry three error bits.
// - baud generator divides the clock by a 16-bit divisor, 1 to 65535.
// - after reset FIFOs are disabled, so trigger levels act as one character.
// - rx and tx triggers independent: fixed selection or programmed level.
// - auto-CTS and auto-RTS enabled separately by feature bits 7 and 6.
// - auto-RTS keeps RTS asserted below halt level, deasserts at it.
// - after auto deassertion, RTS reasserts when level falls to resume level.
// - one more character arriving after RTS deassertion is still accepted.
// - auto-CTS samples CTS before each character, starts only when CTS low.
// - with auto-CTS on, CTS changes raise no host interrupt.
// - CTS returning low resumes sending queued characters.
// - feature bits 3:2 select transmitted resume/stop pair or both pairs.
// - feature bits 1:0 select compared pair, or both pairs as sequences.
// - modem control bit 5 lets any character resume after a stop.
// - special mode compares second stop char, flags without halting, stores it.
// - stop character halts transmitter after current character, may raise interrupt.
// - resume character restarts transmission and clears the stop flag.
// - stop character sent once rx level passes the halt level.
// - after a stop, resume character sent when rx level reaches resume level.
// - flow characters framed as data; short words send only low bits.
// - RTS is active low and high after reset.
// - threshold nibbles count in units of four characters.
`ifndef FLOW_UART_PARAMS_SVH
`define FLOW_UART_PARAMS_SVH

`define ADDR_DATA       8'h00
`define ADDR_IRQ_EN     8'h04
`define ADDR_FIFO_CTRL  8'h08
`define ADDR_LINE_CTRL  8'h0c
`define ADDR_MODEM_CTRL 8'h10
`define ADDR_LINE_STAT  8'h14
`define ADDR_IDENT      8'h18
`define ADDR_FEATURE    8'h1c
`define ADDR_THRESH     8'h20
`define ADDR_TRIG_LVL   8'h24
`define ADDR_DIVISOR    8'h28
`define ADDR_RESUME1    8'h2c
`define ADDR_RESUME2    8'h30
`define ADDR_STOP1      8'h34
`define ADDR_STOP2      8'h38
`define ADDR_STATUS     8'h3c

`define FEAT_AUTO_CTS   7
`define FEAT_AUTO_RTS   6
`define FEAT_SPECIAL    5
`define MODEM_RTS       1
`define MODEM_XON_ANY   5
`define IRQ_EN_STOP     5
`define FIFO_EN         0
`define FIFO_RX_CLR     1
`define FIFO_TX_CLR     2

`define LINE_CTRL_RST   8'h1d
`define DIVISOR_RST     16'h0001
`define FIFO_DEPTH      7'd64
`define TICK_LAST       4'hf
`define TICK_MID        4'h7

`endif

// ### inc/flow_uart_pkg.sv
/*
  Types of the flow-controlled UART channel: serializer states and the state record.
  Assumes the constants header is compiled alongside.
*/
package flow_uart_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

  typedef struct packed {
    logic             rx_meta, rx_sync, cts_meta, cts_sync;
    logic [7:0]       interrupt_enable_reg, fifo_control_reg, line_ctrl_reg;
    logic [7:0]       modem_control_reg, enhanced_feature_reg;
    logic [7:0]       flow_threshold_reg, trigger_level_reg;
    logic [15:0]      divisor, baud_cnt;
    logic [7:0]       resume_char_first, resume_char_second;
    logic [7:0]       stop_char_first, stop_char_second;
    logic             tick;
    tx_state_t        tx_st;
    logic [3:0]       tx_tick;
    logic [2:0]       tx_bit;
    logic [7:0]       tx_shift;
    logic             tx_line;
    logic [63:0][7:0] tx_mem;
    logic [5:0]       tx_wp, tx_rp;
    logic [6:0]       tx_cnt;
    rx_state_t        rx_st;
    logic [3:0]       rx_tick;
    logic [2:0]       rx_bit;
    logic [7:0]       rx_shift;
    logic [63:0][10:0] rx_mem;
    logic [5:0]       rx_wp, rx_rp;
    logic [6:0]       rx_cnt;
    logic             rts_hold, rts_n, stop_sent, ctl_xon, halted, stop_flag;
    logic [1:0]       ctl_left;
    logic             seq_stop, seq_resume;
    logic             dph_write, dph_read;
    logic [7:0]       dph_addr;
    logic [31:0]      hrdata;
  } flow_state_t;
endpackage

// ### src/flow_uart.sv
/*
  One UART channel with FIFOs, trigger levels, hardware and software flow control,
  reached over AHB-Lite. Assumes one 125 MHz clock; rx and cts pins are asynchronous.
*/
// Our own choices: register access over AHB-Lite and the register addresses.
`include "flow_uart_params.svh"

module flow_uart (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // serial line
  input  wire logic        rx_i,
  input  wire logic        cts_n_i,
  output logic             tx_o,
  output logic             rts_n_o,
  // host signalling
  output logic             irq_o,
  output logic             rx_dma_request_n_o,
  output logic             tx_dma_request_n_o
);
  import flow_uart_pkg::*;

  // threshold nibble to character count
  function automatic logic [6:0] times4(input logic [3:0] n);
    return {1'b0, n, 2'b00};
  endfunction

  function automatic logic [7:0] word_mask(input logic [1:0] wl);
    return 8'hff >> (3'd3 - {1'b0, wl});
  endfunction

  localparam flow_state_t RST = '{
    line_ctrl_reg: `LINE_CTRL_RST, divisor: `DIVISOR_RST, tx_line: 1'b1, rts_n: 1'b1,
    rx_meta: 1'b1, rx_sync: 1'b1, cts_meta: 1'b1, cts_sync: 1'b1,
    tx_st: TX_IDLE, rx_st: RX_IDLE, default: '0};

  flow_state_t q, d;
  logic [7:0]  wmask, ch, ctl_ch, wb, rv;
  logic [2:0]  nbits_m1;
  logic [6:0]  cap, halt_lvl, resume_lvl, rx_trig, tx_trig, rx_fix, tx_fix;
  logic        auto_rts, auto_cts, pair_tx, fifo_on;
  logic [1:0]  tx_sw, rx_sw;
  logic        rx_done, store, stop_det, resume_det, spec_det, flow_match;
  logic        rx_push, rx_pop, tx_push, tx_pop, go, frame_err, addr_ok;

  assign wmask      = word_mask(q.line_ctrl_reg[1:0]);
  assign nbits_m1   = 3'd4 + {1'b0, q.line_ctrl_reg[1:0]};
  assign fifo_on    = q.fifo_control_reg[`FIFO_EN];
  // 64 entries when enabled; one entry while disabled
  assign cap        = fifo_on ? `FIFO_DEPTH : 7'd1;
  assign halt_lvl   = times4(q.flow_threshold_reg[3:0]);
  assign resume_lvl = times4(q.flow_threshold_reg[7:4]);
  assign auto_cts   = q.enhanced_feature_reg[`FEAT_AUTO_CTS];
  assign auto_rts   = q.enhanced_feature_reg[`FEAT_AUTO_RTS];
  assign tx_sw      = q.enhanced_feature_reg[3:2];
  assign rx_sw      = q.enhanced_feature_reg[1:0];
  assign pair_tx    = (tx_sw == 2'b11);

  // fixed selections unless a programmed level is nonzero
  always_comb begin
    case (q.fifo_control_reg[7:6])
      2'b00:   rx_fix = 7'd8;
      2'b01:   rx_fix = 7'd16;
      2'b10:   rx_fix = 7'd56;
      default: rx_fix = 7'd60;
    endcase
    case (q.fifo_control_reg[5:4])
      2'b00:   tx_fix = 7'd8;
      2'b01:   tx_fix = 7'd16;
      2'b10:   tx_fix = 7'd32;
      default: tx_fix = 7'd56;
    endcase
    if (!fifo_on) begin
      // trigger of one character after reset
      rx_trig = 7'd1;
      tx_trig = 7'd1;
    end else begin
      rx_trig = (q.trigger_level_reg[7:4] != 4'h0) ? times4(q.trigger_level_reg[7:4]) : rx_fix;
      tx_trig = (q.trigger_level_reg[3:0] != 4'h0) ? times4(q.trigger_level_reg[3:0]) : tx_fix;
    end
  end

  // pair one then pair two when both pairs are selected
  // characters go through the ordinary serializer, low bits first
  always_comb begin
    if (q.ctl_left == 2'd2 || (!pair_tx && tx_sw[1])) begin
      ctl_ch = q.ctl_xon ? q.resume_char_first : q.stop_char_first;
    end else begin
      ctl_ch = q.ctl_xon ? q.resume_char_second : q.stop_char_second;
    end
  end

  always_comb begin
    d          = q;
    ch         = '0;
    wb         = hwdata_i[7:0];
    rv         = '0;
    rx_done    = 1'b0;
    store      = 1'b0;
    stop_det   = 1'b0;
    resume_det = 1'b0;
    spec_det   = 1'b0;
    flow_match = 1'b0;
    rx_pop     = 1'b0;
    tx_push    = 1'b0;
    tx_pop     = 1'b0;
    go         = 1'b0;
    addr_ok    = 1'b1;
    frame_err  = 1'b0;
    d.rx_meta  = rx_i;
    d.rx_sync  = q.rx_meta;
    d.cts_meta = cts_n_i;
    d.cts_sync = q.cts_meta;

    // 16x tick from the divisor, zero treated as one
    d.tick = 1'b0;
    d.baud_cnt = q.baud_cnt + 16'd1;
    if (q.baud_cnt + 16'd1 >= q.divisor) begin
      d.baud_cnt = '0;
      d.tick = 1'b1;
    end

    case (q.tx_st)
      TX_IDLE: begin
        // start only while cts low; resumes once it returns low
        if (q.tick && (!auto_cts || !q.cts_sync)) begin
          if (q.ctl_left != 2'd0) begin
            d.tx_shift = ctl_ch;
            d.ctl_left = q.ctl_left - 2'd1;
            go = 1'b1;
          // halted transmitter sends no queued data
          end else if (q.tx_cnt != 7'd0 && !q.halted) begin
            d.tx_shift = q.tx_mem[q.tx_rp];
            tx_pop = 1'b1;
            go = 1'b1;
          end
        end
        if (go) begin
          d.tx_st = TX_START;
          d.tx_tick = '0;
          d.tx_line = 1'b0;
        end
      end
      TX_START: if (q.tick) begin
        d.tx_tick = q.tx_tick + 4'd1;
        if (q.tx_tick == `TICK_LAST) begin
          d.tx_st = TX_DATA;
          d.tx_bit = '0;
          d.tx_line = q.tx_shift[0];
        end
      end
      TX_DATA: if (q.tick) begin
        d.tx_tick = q.tx_tick + 4'd1;
        if (q.tx_tick == `TICK_LAST) begin
          if (q.tx_bit == nbits_m1) begin
            d.tx_st = TX_STOP;
            d.tx_line = 1'b1;
          end else begin
            d.tx_bit = q.tx_bit + 3'd1;
            d.tx_shift = q.tx_shift >> 1;
            d.tx_line = q.tx_shift[1];
          end
        end
      end
      default: if (q.tick) begin
        d.tx_tick = q.tx_tick + 4'd1;
        if (q.tx_tick == `TICK_LAST) begin
          d.tx_st = TX_IDLE;
        end
      end
    endcase

    case (q.rx_st)
      RX_IDLE: if (q.tick && !q.rx_sync) begin
        d.rx_st = RX_START;
        d.rx_tick = '0;
      end
      RX_START: if (q.tick) begin
        d.rx_tick = q.rx_tick + 4'd1;
        if (q.rx_tick == `TICK_MID) begin
          // false start bit returns to idle
          d.rx_st = q.rx_sync ? RX_IDLE : RX_DATA;
          d.rx_tick = '0;
          d.rx_bit = '0;
        end
      end
      RX_DATA: if (q.tick) begin
        d.rx_tick = q.rx_tick + 4'd1;
        if (q.rx_tick == `TICK_LAST) begin
          d.rx_shift = {q.rx_sync, q.rx_shift[7:1]};
          d.rx_bit = q.rx_bit + 3'd1;
          if (q.rx_bit == nbits_m1) begin
            d.rx_st = RX_STOP;
          end
        end
      end
      default: if (q.tick) begin
        d.rx_tick = q.rx_tick + 4'd1;
        if (q.rx_tick == `TICK_LAST) begin
          d.rx_st = RX_IDLE;
          rx_done = 1'b1;
          frame_err = !q.rx_sync;
          ch = q.rx_shift >> (3'd7 - nbits_m1);
        end
      end
    endcase

    if (rx_done) begin
      store = 1'b1;
      // special character flags and is stored, no halt
      if (q.enhanced_feature_reg[`FEAT_SPECIAL] && ch == (q.stop_char_second & wmask)) begin
        spec_det = 1'b1;
      end else if (rx_sw == 2'b11) begin
        // second must follow first directly, mismatch restarts
        stop_det   = q.seq_stop && ch == (q.stop_char_second & wmask);
        resume_det = q.seq_resume && ch == (q.resume_char_second & wmask);
        d.seq_stop   = ch == (q.stop_char_first & wmask);
        d.seq_resume = ch == (q.resume_char_first & wmask);
        flow_match = stop_det || resume_det || d.seq_stop || d.seq_resume;
      end else if (rx_sw != 2'b00) begin
        stop_det   = ch == ((rx_sw[1] ? q.stop_char_first : q.stop_char_second) & wmask);
        resume_det = ch == ((rx_sw[1] ? q.resume_char_first : q.resume_char_second) & wmask);
        flow_match = stop_det || resume_det;
      end
      // any character but a stop character resumes after a stop
      if (q.modem_control_reg[`MODEM_XON_ANY] && q.halted && !stop_det) begin
        resume_det = 1'b1;
      end
      // flow characters are not data, so they are dropped
      store = !flow_match;
    end
    // room beyond the halt level takes the character in flight
    rx_push = store && (q.rx_cnt < cap);
    if (rx_push) begin
      d.rx_mem[q.rx_wp] = {ch == 8'h00 && frame_err, frame_err, 1'b0, ch};
      d.rx_wp = q.rx_wp + 6'd1;
    end

    // stop halts after the current character; resume clears
    if (resume_det) begin
      d.halted = 1'b0;
      d.stop_flag = 1'b0;
    end
    if (stop_det) begin
      d.halted = 1'b1;
    end

    // deassert at halt level; reassert at resume level
    if (q.flow_threshold_reg[3:0] != 4'h0 && q.rx_cnt >= halt_lvl) begin
      d.rts_hold = 1'b1;
    end else if (q.rx_cnt <= resume_lvl) begin
      d.rts_hold = 1'b0;
    end
    d.rts_n = auto_rts ? q.rts_hold : !q.modem_control_reg[`MODEM_RTS];

    if (tx_sw != 2'b00 && q.ctl_left == 2'd0) begin
      // stop sent once level passes halt
      if (!q.stop_sent && q.flow_threshold_reg[3:0] != 4'h0 && q.rx_cnt > halt_lvl) begin
        d.ctl_left = pair_tx ? 2'd2 : 2'd1;
        d.ctl_xon = 1'b0;
        d.stop_sent = 1'b1;
      // resume sent when level reaches resume
      end else if (q.stop_sent && q.rx_cnt <= resume_lvl) begin
        d.ctl_left = pair_tx ? 2'd2 : 2'd1;
        d.ctl_xon = 1'b1;
        d.stop_sent = 1'b0;
      end
    end

    // ahb data phase
    d.dph_write = 1'b0;
    d.dph_read = 1'b0;
    if (q.dph_read) begin
      if (q.dph_addr == `ADDR_DATA) begin
        rv = q.rx_mem[q.rx_rp][7:0];
        rx_pop = q.rx_cnt != 7'd0;
      end else if (q.dph_addr == `ADDR_IRQ_EN) begin
        rv = q.interrupt_enable_reg;
      end else if (q.dph_addr == `ADDR_FIFO_CTRL) begin
        rv = q.fifo_control_reg;
      end else if (q.dph_addr == `ADDR_LINE_CTRL) begin
        rv = q.line_ctrl_reg;
      end else if (q.dph_addr == `ADDR_MODEM_CTRL) begin
        rv = q.modem_control_reg;
      end else if (q.dph_addr == `ADDR_LINE_STAT) begin
        rv = {1'b0, q.tx_cnt == 7'd0 && q.tx_st == TX_IDLE, q.tx_cnt == 7'd0,
              q.rx_cnt != 7'd0 ? q.rx_mem[q.rx_rp][10:8] : 3'b000, 1'b0, q.rx_cnt != 7'd0};
      end else if (q.dph_addr == `ADDR_IDENT) begin
        rv = {3'b000, irq_o, 3'b000, !irq_o};
        d.stop_flag = 1'b0;
      end else if (q.dph_addr == `ADDR_FEATURE) begin
        rv = q.enhanced_feature_reg;
      end else if (q.dph_addr == `ADDR_THRESH) begin
        rv = q.flow_threshold_reg;
      end else if (q.dph_addr == `ADDR_TRIG_LVL) begin
        rv = q.trigger_level_reg;
      end else if (q.dph_addr == `ADDR_RESUME1) begin
        rv = q.resume_char_first;
      end else if (q.dph_addr == `ADDR_RESUME2) begin
        rv = q.resume_char_second;
      end else if (q.dph_addr == `ADDR_STOP1) begin
        rv = q.stop_char_first;
      end else if (q.dph_addr == `ADDR_STOP2) begin
        rv = q.stop_char_second;
      end else begin
        addr_ok = 1'b0;
      end
      d.hrdata = {24'h000000, rv};
      if (q.dph_addr == `ADDR_DIVISOR) begin
        d.hrdata = {16'h0000, q.divisor};
      end else if (q.dph_addr == `ADDR_STATUS) begin
        d.hrdata = {11'h000, q.stop_sent, q.halted, q.rts_hold, q.tx_cnt, 1'b0, q.rx_cnt,
                    q.cts_sync, q.tx_st == TX_IDLE, q.rx_st == RX_IDLE};
      end else if (!addr_ok) begin
        d.hrdata = '0;
      end
    end
    // set wins over the ident read clear
    if (stop_det || spec_det) begin
      d.stop_flag = 1'b1;
    end

    if (q.dph_write) begin
      if (q.dph_addr == `ADDR_DATA) begin
        tx_push = q.tx_cnt < cap;
      end else if (q.dph_addr == `ADDR_IRQ_EN) begin
        d.interrupt_enable_reg = wb;
      end else if (q.dph_addr == `ADDR_FIFO_CTRL) begin
        d.fifo_control_reg = wb & 8'hf9;
      end else if (q.dph_addr == `ADDR_LINE_CTRL) begin
        d.line_ctrl_reg = wb;
      end else if (q.dph_addr == `ADDR_MODEM_CTRL) begin
        d.modem_control_reg = wb;
      end else if (q.dph_addr == `ADDR_FEATURE) begin
        d.enhanced_feature_reg = wb;
      end else if (q.dph_addr == `ADDR_THRESH) begin
        d.flow_threshold_reg = wb;
      end else if (q.dph_addr == `ADDR_TRIG_LVL) begin
        d.trigger_level_reg = wb;
      end else if (q.dph_addr == `ADDR_DIVISOR) begin
        d.divisor = (hwdata_i[15:0] == 16'h0000) ? 16'h0001 : hwdata_i[15:0];
      end else if (q.dph_addr == `ADDR_RESUME1) begin
        d.resume_char_first = wb;
      end else if (q.dph_addr == `ADDR_RESUME2) begin
        d.resume_char_second = wb;
      end else if (q.dph_addr == `ADDR_STOP1) begin
        d.stop_char_first = wb;
      end else if (q.dph_addr == `ADDR_STOP2) begin
        d.stop_char_second = wb;
      end
    end
    if (tx_push) begin
      d.tx_mem[q.tx_wp] = wb;
      d.tx_wp = q.tx_wp + 6'd1;
    end

    // fifo pointers and levels
    if (tx_pop) begin
      d.tx_rp = q.tx_rp + 6'd1;
    end
    if (rx_pop) begin
      d.rx_rp = q.rx_rp + 6'd1;
    end
    d.tx_cnt = q.tx_cnt + {6'd0, tx_push} - {6'd0, tx_pop};
    d.rx_cnt = q.rx_cnt + {6'd0, rx_push} - {6'd0, rx_pop};
    if (q.dph_write && q.dph_addr == `ADDR_FIFO_CTRL) begin
      if (wb[`FIFO_RX_CLR] || wb[`FIFO_EN] != fifo_on) begin
        d.rx_wp = '0;
        d.rx_rp = '0;
        d.rx_cnt = '0;
      end
      if (wb[`FIFO_TX_CLR] || wb[`FIFO_EN] != fifo_on) begin
        d.tx_wp = '0;
        d.tx_rp = '0;
        d.tx_cnt = '0;
      end
    end

    // ahb address phase
    if (hsel_i && htrans_i[1] && hready_i) begin
      d.dph_write = hwrite_i;
      d.dph_read = !hwrite_i;
      d.dph_addr = haddr_i[7:0];
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign hreadyout_o        = !q.dph_read;
  assign hresp_o            = 1'b0;
  assign hrdata_o           = q.hrdata;
  assign tx_o               = q.tx_line;
  assign rts_n_o            = q.rts_n;
  // interrupt when enabled; cts never feeds it
  assign irq_o              = q.stop_flag && q.interrupt_enable_reg[`IRQ_EN_STOP];
  assign rx_dma_request_n_o = !(q.rx_cnt >= rx_trig);
  assign tx_dma_request_n_o = !((cap - q.tx_cnt) >= tx_trig);

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  rts_halt_a: assert property (
    auto_rts && q.flow_threshold_reg[3:0] != 4'h0 && q.rx_cnt >= halt_lvl
    |=> (q.rts_hold and (auto_rts |=> rts_n_o)))
    else $error("rts not released at halt level");
  rts_resume_a: assert property (
    auto_rts && q.rx_cnt <= resume_lvl && !(q.flow_threshold_reg[3:0] != 4'h0
    && q.rx_cnt >= halt_lvl) |=> (!q.rts_hold and (auto_rts |=> !rts_n_o)))
    else $error("rts not reasserted at resume level");
  cts_gate_a: assert property (
    q.tx_st == TX_IDLE && auto_cts && q.cts_sync |=> q.tx_st == TX_IDLE)
    else $error("character started while cts high");
  stop_halt_a: assert property (
    stop_det |=> q.halted && q.stop_flag)
    else $error("stop character did not halt");
  resume_run_a: assert property (
    resume_det && !stop_det && !spec_det |=> !q.halted && !q.stop_flag)
    else $error("resume character did not restart");
  special_flag_a: assert property (
    spec_det && !q.halted |=> q.stop_flag && !q.halted && $changed(q.rx_wp) || q.rx_cnt == cap)
    else $error("special character mishandled");
  rx_full_a: assert property (
    q.rx_cnt == cap && !rx_pop |=> q.rx_cnt == $past(q.rx_cnt) || $past(q.dph_write))
    else $error("rx fifo grew past capacity");
  fifo_off_a: assert property (
    !fifo_on |-> q.rx_cnt <= 7'd1 && q.tx_cnt <= 7'd1)
    else $error("disabled fifo held more than one");
  irq_level_a: assert property (
    stop_det && q.interrupt_enable_reg[`IRQ_EN_STOP] && !q.dph_write |=> irq_o)
    else $error("stop character raised no interrupt");
  stop_send_a: assert property (
    $rose(q.stop_sent) |-> q.ctl_left != 2'd0 && !q.ctl_xon)
    else $error("stop not queued for sending");

  halt_seen_c: cover property (stop_det ##[1:1000] resume_det);
  rts_cycle_c: cover property (auto_rts && $rose(rts_n_o) ##[1:1000] $fell(rts_n_o));
  stop_sent_c: cover property ($rose(q.stop_sent) ##[1:1000] $fell(q.stop_sent));
endmodule // flow_uart

// ### tb/flow_uart_tb_top.sv
/*
  Bench of the flow-controlled channel: AHB-Lite master, partner, checks.
  Assumes divisor 1 and 8-bit words once configured.
*/
module flow_uart_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_i, reset_n_i, hsel, hwrite, hold, hrdy, hresp;
  logic        tx, rx, cts_n, rts_n, irq, rxd, txd;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [7:0]  c, exp[$];
  int          n_mismatch, total_checks;

  flow_uart DUT (.clock_i(clock_i), .reset_n_i(reset_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp),
    .hrdata_o(hrdata), .rx_i(rx), .cts_n_i(cts_n), .tx_o(tx), .rts_n_o(rts_n),
    .irq_o(irq), .rx_dma_request_n_o(rxd), .tx_dma_request_n_o(txd));
  remote_uart far (.clock_i(clock_i), .line_i(tx), .hold_i(hold), .line_o(rx),
    .cts_n_o(cts_n));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clock_i iff hrdy === 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock_i iff hrdy === 1'b1);
    q = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #500000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    {reset_n_i, hsel, htrans, haddr, hwrite, hwdata, hold} = '0;
    void'($urandom(36854));
    repeat (16) @(posedge clock_i);
    reset_n_i <= 1'b1;
    chk("rts", 1, rts_n);
    chk("txdma", 0, txd);
    chk("rxdma", 1, rxd);
    bus(0, 8'h0c, 0);
    chk("lcr", 32'h1d, q);
    bus(0, 8'h28, 0);
    chk("div", 1, q);
    bus(0, 8'h40, 0);
    chk("unmapped", 0, q);
    chk("resp", 0, hresp);
    bus(1, 8'h0c, 8'h03);
    bus(1, 8'h08, 8'h01);
    for (int i = 0; i < 3; i++) begin
      c = 8'($urandom);
      exp.push_back(c);
      bus(1, 8'h00, {24'h0, c});
    end
    repeat (700) @(posedge clock_i);
    for (int i = 0; i < 3; i++) chk("txchar", exp[i], far.got[i]);
    far.got.delete();
    bus(1, 8'h1c, 8'h80);
    hold <= 1'b1;
    bus(1, 8'h00, 8'h5a);
    repeat (400) @(posedge clock_i);
    chk("ctsheld", 0, far.got.size());
    hold <= 1'b0;
    repeat (400) @(posedge clock_i);
    chk("ctsgo", 8'h5a, far.got.pop_front());
    bus(1, 8'h1c, 8'h40);
    bus(1, 8'h20, 8'h12);
    repeat (4) @(posedge clock_i);
    chk("rtson", 0, rts_n);
    exp.delete();
    for (int i = 0; i < 8; i++) begin
      c = 8'($urandom);
      exp.push_back(c);
      far.send(c);
    end
    repeat (20) @(posedge clock_i);
    chk("rtsoff", 1, rts_n);
    far.send(8'h77);
    repeat (20) @(posedge clock_i);
    bus(0, 8'h3c, 0);
    chk("rxlevel", 9, q[9:3]);
    chk("rxdma", 0, rxd);
    for (int i = 0; i < 5; i++) begin
      bus(0, 8'h00, 0);
      chk("rxchar", exp[i], q[7:0]);
    end
    repeat (4) @(posedge clock_i);
    chk("rtsback", 0, rts_n);
    bus(1, 8'h08, 8'h03);
    bus(1, 8'h1c, 8'h02);
    bus(1, 8'h2c, 8'h11);
    bus(1, 8'h34, 8'h13);
    bus(1, 8'h04, 8'h20);
    far.send(8'h13);
    repeat (20) @(posedge clock_i);
    chk("irqset", 1, irq);
    bus(1, 8'h00, 8'ha5);
    repeat (400) @(posedge clock_i);
    chk("halted", 0, far.got.size());
    far.send(8'h11);
    repeat (400) @(posedge clock_i);
    chk("irqclr", 0, irq);
    chk("resumed", 8'ha5, far.got.pop_front());
    bus(1, 8'h1c, 8'h0a);
    bus(1, 8'h20, 8'h01);
    for (int i = 0; i < 5; i++) far.send(8'h20 + 8'($urandom % 64));
    repeat (200) @(posedge clock_i);
    chk("stopsent", 8'h13, far.got.pop_front());
    for (int i = 0; i < 5; i++) bus(0, 8'h00, 0);
    repeat (200) @(posedge clock_i);
    chk("resumesent", 8'h11, far.got.pop_front());
    bus(1, 8'h38, 8'h7e);
    bus(1, 8'h1c, 8'h2a);
    far.send(8'h7e);
    repeat (20) @(posedge clock_i);
    chk("specirq", 1, irq);
    bus(0, 8'h18, 0);
    chk("ident", 32'h10, q);
    chk("specclr", 0, irq);
    bus(0, 8'h00, 0);
    chk("specstored", 8'h7e, q);
    bus(1, 8'h1c, 8'h0b);
    far.send(8'h13);
    far.send(8'h7e);
    bus(0, 8'h3c, 0);
    chk("pairstop", 1, q[19]);
    far.send(8'h11);
    far.send(8'h5a);
    bus(0, 8'h3c, 0);
    chk("pairbroken", 1, q[19]);
    bus(1, 8'h10, 8'h20);
    far.send(8'h41);
    bus(0, 8'h3c, 0);
    chk("anyresume", 0, q[19]);
    end_sim();
  end
endmodule // flow_uart_tb_top

// ### tb/remote_uart.sv
/*
  Far-end serial partner: sends and collects 8-bit frames, drives clear-to-send.
  Assumes divisor 1, so one bit is 16 clocks.
*/
module remote_uart (
  // clock
  input  wire logic clock_i,
  // serial line
  input  wire logic line_i,
  input  wire logic hold_i,
  output logic      line_o,
  output logic      cts_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic [7:0] b;
  assign cts_n_o = hold_i;
  initial line_o = 1'b1;
  // one start, lsb first, one stop
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clock_i);
      line_o <= f[i];
      repeat (15) @(posedge clock_i);
    end
  endtask
  initial forever begin
    @(negedge line_i);
    repeat (8) @(posedge clock_i);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge clock_i);
      b[i] = line_i;
    end
    repeat (16) @(posedge clock_i);
    got.push_back(b);
  end
endmodule // remote_uart
